// >>> verilog/audio_clock_source_select.sv
// Our own choices: the address map and strobed register access.
`timescale 1ns/10ps
// Function
// - Word clock output follows active sample rate
// - Single speed divides word clock to 32-48k
// - Source is master or one of six inputs
// - Unlocked chosen input falls to next locked
// - No locked input means internal clock
// - Effective source readable by host
// - Per input no lock, lock or sync
// - Per input coarse rate class reported
// - MADI channel and frame format reported
// - Pitch offset 1 Hz steps within 5%
// - Video pull presets 0.1% and 4%
// - Pitch acts only in master mode
module audio_clock_source_select
    import clk_src_pkg::*;
#(
    parameter int NIN = N_INPUTS
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic [NIN-1:0] ref_clk_i,
    input wire logic [3:0] madi_fmt_i,
    output logic word_clk_o,
    output logic irq_o
);

    typedef struct packed {
        logic [31:0] rdata;
        logic [2:0] cfg_src;
        logic single;
        logic [3:0] rate_sel;
        logic [2:0] pull;
        logic [15:0] pitch;
        logic [2:0] eff_src;
        logic [NIN-1:0] lock_prev;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [ACC_W-1:0] acc;
        logic prev_src;
        logic [1:0] div_cnt;
        logic wc;
        logic [3:0] m1;
        logic [3:0] m2;
        logic [3:0] m3;
        logic [3:0] madi;
    } top_s;

    top_s q;
    top_s n;
    logic [NIN-1:0] lock;
    logic [NIN-1:0] level;
    logic [NIN-1:0] sync;
    logic [3:0] rclass [NIN];
    logic [3:0] act_class;
    logic [2:0] eff_idx;
    logic src_lvl;
    logic [17:0] base_hz;
    logic [17:0] span;
    logic [17:0] pull_off;
    logic signed [19:0] pitch_c;
    logic signed [19:0] target;
    logic [SYN_K_W+19:0] prod;
    logic [1:0] irq_clr;
    logic [1:0] events;

    // One monitor per reference input
    for (genvar i = 0; i < NIN; i++)
    begin : g_mon
        ref_input_monitor u_mon
        (
            .core_clk_i(core_clk_i),
            .rst_i(rst_i),
            .ref_i(ref_clk_i[i]),
            .level_o(level[i]),
            .lock_o(lock[i]),
            .rate_class_o(rclass[i])
        );
    end

    // Nominal rate of a class in Hz; illegal codes give 48 kHz
    function automatic logic [17:0] nominal_hz(input logic [3:0] c);
        unique case (c)
            RC_32K: return 18'd32000;
            RC_44K1: return 18'd44100;
            RC_64K: return 18'd64000;
            RC_88K2: return 18'd88200;
            RC_96K: return 18'd96000;
            RC_128K: return 18'd128000;
            RC_176K4: return 18'd176400;
            RC_192K: return 18'd192000;
            default: return 18'd48000;
        endcase
    endfunction

    // Scale a rate by a fraction over 2^16
    function automatic logic [17:0] frac(input logic [17:0] hz,
                                         input logic [11:0] f);
        logic [29:0] p;
        p = hz * f;
        return 18'(p >> 16);
    endfunction

    // First locked input after the configured one, else master
    function automatic logic [2:0] next_locked(input logic [2:0] start,
                                               input logic [NIN-1:0] lk);
        logic [2:0] idx;
        logic [2:0] found;
        idx = start;
        found = SRC_MASTER;
        for (int k = 0; k < NIN; k++)
        begin
            idx = (idx == 3'(NIN)) ? 3'h1 : idx + 3'h1;
            if (found == SRC_MASTER && lk[idx - 3'h1])
                found = idx;
        end
        return found;
    endfunction

    // Sync means locked and at the rate the device runs on
    always_comb
    begin
        for (int i = 0; i < NIN; i++)
            sync[i] = lock[i] && (rclass[i] == act_class);
    end

    // Synthesizer target: base, preset pull and clamped fine pitch
    always_comb
    begin
        base_hz = nominal_hz(q.rate_sel);
        span = frac(base_hz, FRAC_5PCT);
        pitch_c = 20'($signed(q.pitch));
        // Offset range limited around nominal
        if (pitch_c > $signed({2'b00, span}))
            pitch_c = $signed({2'b00, span});
        else if (pitch_c < -$signed({2'b00, span}))
            pitch_c = -$signed({2'b00, span});
        // Video pull presets
        unique case (q.pull)
            PULL_UP_01, PULL_DN_01: pull_off = frac(base_hz, FRAC_01PCT);
            PULL_UP_4, PULL_DN_4: pull_off = frac(base_hz, FRAC_4PCT);
            default: pull_off = 18'h0;
        endcase
        if (q.pull == PULL_DN_01 || q.pull == PULL_DN_4)
            target = $signed({2'b00, base_hz})
                - $signed({2'b00, pull_off}) + pitch_c;
        else
            target = $signed({2'b00, base_hz})
                + $signed({2'b00, pull_off}) + pitch_c;
        prod = (SYN_K_W + 20)'($unsigned(target))
            * (SYN_K_W + 20)'(SYN_K);
    end

    always_comb
    begin
        n = q;
        irq_clr = 2'h0;
        // MADI format pins, a change counts once stages agree
        n.m1 = madi_fmt_i;
        n.m2 = q.m1;
        n.m3 = q.m2;
        if (q.m2 == q.m3)
            n.madi = q.m3;

        // Source choice with automatic_source_fallback
        if (q.cfg_src == SRC_MASTER || q.cfg_src > 3'(NIN))
            n.eff_src = SRC_MASTER;
        else if (lock[q.cfg_src - 3'h1])
            n.eff_src = q.cfg_src;
        else if (q.eff_src != SRC_MASTER && lock[q.eff_src - 3'h1])
            n.eff_src = q.eff_src; // Stay on a fallback still locked
        else
            n.eff_src = next_locked(q.cfg_src, lock);

        // Active rate and source level for the word clock
        eff_idx = q.eff_src - 3'h1;
        if (q.eff_src == SRC_MASTER)
        begin
            act_class = q.rate_sel;
            src_lvl = q.acc[ACC_W-1];
            // Pitch only moves the internal synthesizer
            n.acc = q.acc + ACC_W'(prod >> SYN_SHIFT);
        end
        else
        begin
            act_class = rclass[eff_idx];
            src_lvl = level[eff_idx];
            n.acc = '0;
        end

        // Word clock at active rate, optionally single speed
        n.prev_src = src_lvl;
        if (src_lvl && !q.prev_src)
            n.div_cnt = q.div_cnt + 2'h1;
        if (!q.single || act_class <= RC_48K)
            n.wc = src_lvl;
        else if (act_class <= RC_96K)
            n.wc = q.div_cnt[0]; // Halved to stay in range
        else
            n.wc = q.div_cnt[1]; // Quartered

        // Register writes
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                REG_CTRL:
                begin
                    n.cfg_src = reg_wdata_i[CTRL_SRC_LSB +: 3];
                    n.single = reg_wdata_i[CTRL_SINGLE_BIT];
                    n.rate_sel = reg_wdata_i[CTRL_RATE_LSB +: 4];
                    n.pull = reg_wdata_i[CTRL_PULL_LSB +: 3];
                end
                REG_PITCH: n.pitch = reg_wdata_i[15:0];
                REG_IRQ_MASK: n.irq_mask = reg_wdata_i[1:0];
                default: ;
            endcase
        end

        // Register reads, data stands only in the next cycle
        n.rdata = '0;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                REG_CTRL:
                begin
                    n.rdata[CTRL_SRC_LSB +: 3] = q.cfg_src;
                    n.rdata[CTRL_SINGLE_BIT] = q.single;
                    n.rdata[CTRL_RATE_LSB +: 4] = q.rate_sel;
                    n.rdata[CTRL_PULL_LSB +: 3] = q.pull;
                end
                REG_PITCH: n.rdata[15:0] = q.pitch;
                REG_STATUS:
                begin
                    // Source chosen this cycle, in step with the lock bits
                    n.rdata[2:0] = n.eff_src;
                    n.rdata[STAT_LOCK_LSB +: NIN] = lock;
                    n.rdata[STAT_SYNC_LSB +: NIN] = sync;
                end
                REG_RATES:
                begin
                    for (int i = 0; i < NIN; i++)
                        n.rdata[4*i +: 4] = rclass[i];
                end
                REG_MADI: n.rdata[3:0] = q.madi;
                REG_IRQ_STAT:
                begin
                    n.rdata[1:0] = q.irq_stat;
                    irq_clr = 2'h3;
                end
                REG_IRQ_MASK: n.rdata[1:0] = q.irq_mask;
                default: ;
            endcase
        end

        // Sticky events; a new event beats a read clear
        events = '0;
        events[IRQ_SRC_BIT] = n.eff_src != q.eff_src;
        events[IRQ_LOCK_BIT] = lock != q.lock_prev;
        n.lock_prev = lock;
        n.irq_stat = (q.irq_stat & ~irq_clr) | events;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            q <= '0;
            q.rate_sel <= RATE_RST;
            q.cfg_src <= SRC_RST;
        end
        else
            q <= n;
    end

    assign reg_rdata_o = q.rdata;
    assign word_clk_o = q.wc;
    assign irq_o = |(q.irq_stat & q.irq_mask);

endmodule

// >>> verilog/clk_src_pkg.sv
package clk_src_pkg;

    // Core clock and derived synthesizer step scale
    localparam longint CORE_CLK_HZ = 200_000_000;
    localparam longint SYN_K = ((64'd1 << 40) + CORE_CLK_HZ / 2) / CORE_CLK_HZ;
    localparam int SYN_K_W = 13;
    localparam int SYN_SHIFT = 8;
    localparam int ACC_W = 32;

    // Reference inputs and clock source codes
    localparam int N_INPUTS = 6;
    localparam logic [2:0] SRC_MASTER = 3'h0;
    localparam logic [2:0] SRC_WORD = 3'h1;
    localparam logic [2:0] SRC_AES = 3'h2;
    localparam logic [2:0] SRC_OPT1 = 3'h3;
    localparam logic [2:0] SRC_OPT2 = 3'h4;
    localparam logic [2:0] SRC_MADI_OPT = 3'h5;
    localparam logic [2:0] SRC_MADI_COAX = 3'h6;

    // Rate classes, 0 means no rate recognised
    localparam logic [3:0] RC_NONE = 4'h0;
    localparam logic [3:0] RC_32K = 4'h1;
    localparam logic [3:0] RC_44K1 = 4'h2;
    localparam logic [3:0] RC_48K = 4'h3;
    localparam logic [3:0] RC_64K = 4'h4;
    localparam logic [3:0] RC_88K2 = 4'h5;
    localparam logic [3:0] RC_96K = 4'h6;
    localparam logic [3:0] RC_128K = 4'h7;
    localparam logic [3:0] RC_176K4 = 4'h8;
    localparam logic [3:0] RC_192K = 4'h9;

    // Period measurement: class borders in Hz, converted to core cycles
    localparam int PERIOD_CNT_W = 13;
    localparam longint BORDER_HZ_0 = 37_100;
    localparam longint BORDER_HZ_1 = 46_000;
    localparam longint BORDER_HZ_2 = 54_900;
    localparam longint BORDER_HZ_3 = 74_200;
    localparam longint BORDER_HZ_4 = 92_000;
    localparam longint BORDER_HZ_5 = 109_700;
    localparam longint BORDER_HZ_6 = 148_300;
    localparam longint BORDER_HZ_7 = 184_000;
    localparam longint MIN_RATE_HZ = 28_000;
    localparam longint MAX_RATE_HZ = 210_000;
    localparam logic [12:0] PERIOD_MAX = 13'(CORE_CLK_HZ / MIN_RATE_HZ);
    localparam logic [12:0] PERIOD_MIN = 13'(CORE_CLK_HZ / MAX_RATE_HZ);
    localparam logic [12:0] LOCK_TOL = 13'h008;
    localparam logic [2:0] LOCK_COUNT = 3'h4;

    // Register byte offsets
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_PITCH = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_RATES = 5'h0c;
    localparam logic [4:0] REG_MADI = 5'h10;
    localparam logic [4:0] REG_IRQ_STAT = 5'h14;
    localparam logic [4:0] REG_IRQ_MASK = 5'h18;

    // Field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_SINGLE_BIT = 3;
    localparam int CTRL_RATE_LSB = 4;
    localparam int CTRL_PULL_LSB = 8;
    localparam int STAT_LOCK_LSB = 8;
    localparam int STAT_SYNC_LSB = 16;
    localparam int IRQ_SRC_BIT = 0;
    localparam int IRQ_LOCK_BIT = 1;

    // Reset values
    localparam logic [3:0] RATE_RST = RC_48K;
    localparam logic [2:0] SRC_RST = SRC_MASTER;

    // Video pull presets
    localparam logic [2:0] PULL_NONE = 3'h0;
    localparam logic [2:0] PULL_UP_01 = 3'h1;
    localparam logic [2:0] PULL_DN_01 = 3'h2;
    localparam logic [2:0] PULL_UP_4 = 3'h3;
    localparam logic [2:0] PULL_DN_4 = 3'h4;
    // Fractions as multipliers over 2^16
    localparam logic [11:0] FRAC_5PCT = 12'hccd;
    localparam logic [11:0] FRAC_4PCT = 12'ha3d;
    localparam logic [11:0] FRAC_01PCT = 12'h042;

    // Rate class from a measured period in core cycles
    function automatic logic [3:0] class_of(input logic [12:0] per);
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_0)) return RC_32K;
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_1)) return RC_44K1;
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_2)) return RC_48K;
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_3)) return RC_64K;
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_4)) return RC_88K2;
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_5)) return RC_96K;
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_6)) return RC_128K;
        if (per >= 13'(CORE_CLK_HZ / BORDER_HZ_7)) return RC_176K4;
        return RC_192K;
    endfunction

endpackage

// >>> verilog/ref_input_monitor.sv
`timescale 1ns/10ps
module ref_input_monitor
    import clk_src_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ref_i,
    output logic level_o,
    output logic lock_o,
    output logic [3:0] rate_class_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic [12:0] cnt;
        logic [12:0] last_per;
        logic [2:0] good;
        logic lock;
        logic [3:0] rclass;
    } mon_s;

    mon_s q;
    mon_s n;
    logic rise;
    logic [12:0] diff;

    // Edge measurement; only agreeing second and third stages count
    always_comb
    begin
        n = q;
        n.s1 = ref_i;
        n.s2 = q.s1;
        n.s3 = q.s2;
        rise = (q.s2 == q.s3) && q.s3 && !q.level;
        diff = (q.cnt > q.last_per) ? q.cnt - q.last_per
                                    : q.last_per - q.cnt;
        if (q.s2 == q.s3)
            n.level = q.s3;
        if (rise)
        begin
            n.cnt = 13'h001;
            n.last_per = q.cnt;
            // Lock needs several equal periods in a row
            if (q.cnt >= PERIOD_MIN && diff <= LOCK_TOL)
            begin
                if (q.good != LOCK_COUNT)
                    n.good = q.good + 3'h1;
                else
                begin
                    n.lock = 1'b1;
                    n.rclass = class_of(q.cnt);
                end
            end
            else
            begin
                n.good = 3'h0;
                n.lock = 1'b0;
                n.rclass = RC_NONE;
            end
        end
        else if (q.cnt >= PERIOD_MAX)
        begin
            // Missing edges drop lock without host help
            n.good = 3'h0;
            n.lock = 1'b0;
            n.rclass = RC_NONE;
        end
        else
            n.cnt = q.cnt + 13'h001;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            q <= '0;
        else
            q <= n;
    end

    assign level_o = q.level;
    assign lock_o = q.lock;
    assign rate_class_o = q.rclass;

endmodule

// >>> testbench/audio_clock_source_select_assertions.sv
`timescale 1ns/10ps
module audio_clock_source_select_assertions
    import clk_src_pkg::*;
#(
    parameter int NIN = N_INPUTS
)
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [3:0] madi_fmt_i,
    input wire logic word_clk_o,
    input wire logic irq_o
);
    logic [14:0] quiet_q;
    logic prev_q;

    // Cycles since the word clock last moved, saturating
    always_ff @(posedge core_clk_i)
    begin
        prev_q <= word_clk_o;
        if (rst_i || word_clk_o != prev_q)
            quiet_q <= 15'h0;
        else if (quiet_q != 15'h7fff)
            quiet_q <= quiet_q + 15'h1;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // Outputs leave reset quiet
    a_reset_quiet: assert property ($fell(rst_i) |->
        !word_clk_o && !irq_o && reg_rdata_o == 32'h0)
        else $error("outputs not quiet after reset");
    a_rdata_idle: assert property (!$past(reg_rd_i) |->
        reg_rdata_o == 32'h0) else $error("read data outside read slot");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i >= 5'h1c
        |=> reg_rdata_o == 32'h0) else $error("unmapped read not zero");
    a_ctrl_back: assert property ((reg_wr_i && reg_addr_i == REG_CTRL)
        ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == REG_CTRL)
        |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 32'h7ff))
        else $error("control readback differs");
    a_status_form: assert property (reg_rd_i && reg_addr_i == REG_STATUS
        |=> reg_rdata_o[2:0] <= 3'h6 && reg_rdata_o[7:3] == 5'h0
        && reg_rdata_o[15:14] == 2'h0 && reg_rdata_o[31:22] == 10'h0
        && (reg_rdata_o[21:16] & ~reg_rdata_o[13:8]) == 6'h0)
        else $error("status layout broken");
    a_src_locked: assert property (reg_rd_i && reg_addr_i == REG_STATUS
        |=> reg_rdata_o[2:0] == 3'h0
        || reg_rdata_o[5'd7 + 5'(reg_rdata_o[2:0])])
        else $error("effective input not locked");
    a_irq_pending: assert property (reg_rd_i && reg_addr_i == REG_IRQ_STAT
        && irq_o |=> reg_rdata_o[1:0] != 2'h0)
        else $error("interrupt without status");
    a_mask_off: assert property (reg_wr_i && reg_addr_i == REG_IRQ_MASK
        && reg_wdata_i[1:0] == 2'h0 |=> !irq_o)
        else $error("interrupt despite zero mask");
    a_madi_sync: assert property ($stable(madi_fmt_i) [*6] ##0
        (reg_rd_i && reg_addr_i == REG_MADI)
        |=> reg_rdata_o == {28'h0, $past(madi_fmt_i)})
        else $error("format readback differs");
    // Long stall is allowed for fallback after a lost input only
    a_word_alive: assert property (quiet_q < 15'd16000)
        else $error("word clock stalled");

    c_irq: cover property ($rose(irq_o));
    c_word: cover property ($rose(word_clk_o));
    c_fallback: cover property (reg_rd_i && reg_addr_i == REG_STATUS
        ##1 reg_rdata_o[2:0] == SRC_MADI_OPT);
endmodule

bind audio_clock_source_select audio_clock_source_select_assertions
    #(.NIN(NIN)) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .madi_fmt_i(madi_fmt_i), .word_clk_o(word_clk_o), .irq_o(irq_o));

// >>> testbench/ref_src_model.sv
`timescale 1ns/10ps
module ref_src_model
(
    input wire logic [5:0] en_i,
    input wire logic [5:0][13:0] half_ns_i,
    output logic [5:0] ref_clk_o
);
    // Each source toggles at its own rate; a dead one sits low, no edges
    for (genvar g = 0; g < 6; g++)
    begin : gen_src
        initial
        begin
            ref_clk_o[g] = 1'b0;
            #(g * 7 + 1); // Phase unrelated to the core clock
            forever
            begin
                if (en_i[g])
                begin
                    #(half_ns_i[g]);
                    ref_clk_o[g] = ~ref_clk_o[g];
                end
                else
                begin
                    ref_clk_o[g] = 1'b0;
                    #5;
                end
            end
        end
    end
endmodule

// >>> testbench/test_audio_clock_source_select.sv
`timescale 1ns/10ps
module test_audio_clock_source_select
    import clk_src_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [4:0] reg_addr_i = 5'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [5:0] ref_clk;
    logic [5:0] src_en = 6'h0;
    logic [5:0][13:0] half_ns = {14'd2604, 14'd5208, {4{14'd2604}}};
    logic [3:0] madi_fmt_i = 4'h0;
    logic word_clk_o;
    logic irq_o;
    logic [31:0] exp_q[$];
    logic rd_seen = 1'b0;
    int n_fail = 0;
    int checked = 0;
    int pv;
    logic [4:0] za[6] = '{REG_PITCH, REG_STATUS, REG_RATES, REG_MADI,
        REG_IRQ_MASK, 5'h1c};
    real pf[5] = '{0.0, 0.001, -0.001, 0.04, -0.04};

    always #2.5 core_clk_i = ~core_clk_i;

    audio_clock_source_select dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .ref_clk_i(ref_clk), .madi_fmt_i(madi_fmt_i),
        .word_clk_o(word_clk_o), .irq_o(irq_o));
    ref_src_model srcs (.en_i(src_en), .half_ns_i(half_ns),
        .ref_clk_o(ref_clk));

    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Gap cycle after each strobe keeps every driver assignment unique
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(posedge core_clk_i);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge core_clk_i)
    begin
        if (rd_seen === 1'b1 && exp_q.size() > 0)
            check("reg_rdata_o", reg_rdata_o, exp_q.pop_front());
        rd_seen <= reg_rd_i;
    end

    // Word clock period over n cycles of it, from a rising edge
    task automatic per(input int n, input real hz);
        int k;
        int c;
        logic p;
        real e;
        k = 0;
        c = 0;
        p = word_clk_o;
        for (int t = 0; t < 40000 && k <= n; t++)
        begin
            @(posedge core_clk_i);
            if (k > 0)
                c++;
            if (word_clk_o === 1'b1 && p === 1'b0)
                k++;
            p = word_clk_o;
        end
        e = n * 2.0e8 / hz;
        check("word_clk_o period", {31'h0, c > e - 3.0 && c < e + 3.0},
            32'h1);
    endtask

    task automatic wait_irq(input logic [31:0] e);
        int k;
        k = 0;
        while (irq_o !== 1'b1 && k < 16000)
        begin
            @(posedge core_clk_i);
            k++;
        end
        repeat (4) @(posedge core_clk_i);
        check("irq_o raised", {31'h0, irq_o}, 32'h1);
        rd(REG_IRQ_STAT, e);
        check("irq_o cleared", {31'h0, irq_o}, 32'h0);
    endtask

    // Main sequence: defaults, master synthesis, inputs, formats
    initial
    begin
        void'($urandom(32'hb648));
        repeat (4) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(REG_CTRL, 32'h30);
        foreach (za[i]) rd(za[i], 32'h0);
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            wr(REG_CTRL, {21'h0, 3'(i), 8'h90});
            rd(REG_CTRL, {21'h0, 3'(i), 8'h90});
            per(5, 192000.0 * (1.0 + pf[i]));
        end
        wr(REG_CTRL, 32'h90);
        pv = -(50 * int'($urandom_range(40, 1))
            + int'($urandom_range(49, 0)));
        wr(REG_PITCH, {16'h0, pv[15:0]});
        rd(REG_PITCH, {16'h0, pv[15:0]});
        per(6, 192000.0 + pv);
        wr(REG_CTRL, 32'h98);
        // Let the divider switch settle so no false edge starts the count
        repeat (2) @(posedge core_clk_i);
        per(1, (192000.0 + pv) / 4.0);
        $display("test master done");
        wr(REG_IRQ_MASK, 32'h2);
        wr(REG_CTRL, 32'h91);
        src_en <= 6'h02;
        wait_irq(32'h3);
        rd(REG_STATUS, 32'h00020202);
        rd(REG_RATES, 32'h90);
        wr(REG_IRQ_MASK, 32'h3);
        per(2, 1.0e9 / 5208.0);
        src_en <= 6'h12;
        wait_irq(32'h2);
        rd(REG_STATUS, 32'h00021202);
        rd(REG_RATES, 32'h00060090);
        src_en <= 6'h10;
        wait_irq(32'h3);
        rd(REG_STATUS, 32'h00101005);
        // Single speed on a 96k input halves the word clock
        wr(REG_CTRL, 32'h99);
        repeat (2) @(posedge core_clk_i);
        per(1, 1.0e9 / 20832.0);
        src_en <= 6'h00;
        wait_irq(32'h3);
        rd(REG_STATUS, 32'h0);
        $display("test fallback done");
        repeat (2)
        begin
            madi_fmt_i <= 4'($urandom);
            repeat (8) @(posedge core_clk_i);
            rd(REG_MADI, {28'h0, madi_fmt_i});
        end
        wr(REG_IRQ_MASK, 32'h0);
        $display("test format done");
        repeat (2) @(posedge core_clk_i);
        end_sim();
    end

    // Hang guard at 100000 core cycles, only a little past the expected run length
    initial
    begin
        #(100000 * 5);
        n_fail++;
        end_sim();
    end
endmodule
